/* lct_bus_model.sv */
`timescale 1ns/100ps
module lct_bus_model (
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic [3:0] bus_be,
   output logic bus_ack,
   output logic [31:0] bus_rdata
);
   logic [31:0] mem [logic [29:0]];
   logic [31:0] cur;
   logic [31:0] last_addr = 32'h0;
   int n_rd = 0;
   int n_wr = 0;
   int wait_c = 0;
   initial
   begin
      bus_ack = 1'b0;
      bus_rdata = 32'h0;
   end
   always @(posedge clk_sys)
   begin
      cur = mem.exists(bus_addr[31:2]) ? mem[bus_addr[31:2]] : ({bus_addr[31:2], 2'h0} ^ 32'h3c5a96e1);
      if (bus_req && bus_ack)
      begin
         // data inverted after the beat so a late sample never matches
         bus_ack <= 1'b0;
         bus_rdata <= ~bus_rdata;
         last_addr <= bus_addr;
         wait_c <= slow ? (n_rd + n_wr) % 3 : 0;
         if (bus_we)
         begin
            for (int b = 0; b < 4; b++)
               if (bus_be[b])
                  cur[8*b +: 8] = bus_wdata[8*b +: 8];
            mem[bus_addr[31:2]] = cur;
            n_wr <= n_wr + 1;
         end
         else
            n_rd <= n_rd + 1;
      end
      else if (bus_req && wait_c != 0)
         wait_c <= wait_c - 1;
      else if (bus_req)
      begin
         bus_ack <= 1'b1;
         bus_rdata <= cur;
      end
   end
endmodule : lct_bus_model

/* lct_params.svh */
// Contract
// R1: instruction cache 4 KB, two-way, physical
// R2: fetch hit one cycle, miss no extra
// R3: four-word blocks, four-beat fill, LRU victim
// R4: locked instruction blocks never replaced
// R5: data cache 4 KB, two-way, physical
// R6: data hit one cycle, miss one extra
// R7: data blocks four words, burst fill, LRU
// R8: locked data blocks never replaced
// R9: page selects copy-back or write-through stores
// R10: page attribute inhibits or permits caching
// R11: each side has 32-entry associative buffer
// R12: page sizes 4K,16K,256K,512K,8M
// R13: 16 address spaces, 8 protection groups
// R14: software walk, three scratch registers
// R15: inhibited access single transfer, no allocate
// R16: dirty copy-back victim written before fill
`ifndef LCT_PARAMS_SVH
`define LCT_PARAMS_SVH
`define LCT_SETS 128
`define LCT_WPL 4
`define LCT_IDX_LO 4
`define LCT_IDX_HI 10
`define LCT_TAG_LO 11
`define LCT_LAST_BEAT 2'h3
`define LCT_TLB_N 32
`define LCT_NSCR 3
`define LCT_M4K 20'h00000
`define LCT_M16K 20'h00003
`define LCT_M256K 20'h0003f
`define LCT_M512K 20'h0007f
`define LCT_M8M 20'h007ff
`define LCT_LRU_RST 1'b0
`endif

/* lct_pkg.sv */
package lct_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WB = 2'h1,
      ST_FILL = 2'h2,
      ST_ONE = 2'h3
   } lct_state_t;
   typedef enum logic [2:0] {
      PS_4K = 3'h0,
      PS_16K = 3'h1,
      PS_256K = 3'h2,
      PS_512K = 3'h3,
      PS_8M = 3'h4
   } lct_psize_t;
   typedef struct packed {
      logic vld;
      logic [19:0] epn;
      logic [3:0] asid;
      lct_psize_t ps;
      logic [19:0] rpn;
      logic [2:0] grp;
      logic wt;
      logic ci;
   } lct_tlbe_t;
endpackage : lct_pkg

/* lct_props.sv */
`timescale 1ns/100ps
module lct_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic if_req,
   input wire logic if_ack,
   input wire logic dc_req,
   input wire logic dc_ack,
   input wire logic [1:0] scr_sel,
   input wire logic [31:0] scr_rdata,
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic bus_burst,
   input wire logic [31:0] bus_addr,
   input wire logic bus_ack
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // ----------
   // bus beats
   // ----------
   property p_beat_hold;
      bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we) && $stable(bus_burst);
   endproperty
   a_beat_hold: assert property (p_beat_hold) else $error("bus request moved before its beat");
   property p_burst_step;
      bus_req && bus_burst && bus_ack && bus_addr[3:2] != 2'h3 |=> bus_req && bus_burst && bus_addr == $past(bus_addr) + 32'h4;
   endproperty
   a_burst_step: assert property (p_burst_step) else $error("burst word did not advance");
   property p_burst_base;
      $rose(bus_req) && bus_burst |-> bus_addr[3:0] == 4'h0;
   endproperty
   a_burst_base: assert property (p_burst_base) else $error("burst not at word 0");
   property p_wb_then_fill;
      bus_req && bus_burst && bus_we && bus_ack && bus_addr[3:2] == 2'h3 |-> ##[1:3] (bus_req && bus_burst && !bus_we);
   endproperty
   a_wb_then_fill: assert property (p_wb_then_fill) else $error("no fill after write-back");
   // ----------
   // core answers
   // ----------
   property p_fill_done;
      bus_req && bus_burst && !bus_we && bus_ack && bus_addr[3:2] == 2'h3 |-> (##1 if_ack) or (##2 dc_ack);
   endproperty
   a_fill_done: assert property (p_fill_done) else $error("fill answer late");
   property p_single_done;
      bus_req && !bus_burst && bus_ack |=> if_ack || dc_ack;
   endproperty
   a_single_done: assert property (p_single_done) else $error("single transfer unanswered");
   property p_if_pulse;
      if_ack |-> $past(if_req) ##1 !if_ack;
   endproperty
   a_if_pulse: assert property (p_if_pulse) else $error("fetch answer malformed");
   property p_dc_pulse;
      dc_ack |-> $past(dc_req) ##1 !dc_ack;
   endproperty
   a_dc_pulse: assert property (p_dc_pulse) else $error("data answer malformed");
   property p_scr_unmapped;
      scr_sel == 2'h3 |-> scr_rdata == 32'h0;
   endproperty
   a_scr_unmapped: assert property (p_scr_unmapped) else $error("unmapped scratch not zero");
endmodule : lct_props
bind lct_top lct_props u_props (.clk_sys, .rst, .if_req, .if_ack, .dc_req, .dc_ack, .scr_sel, .scr_rdata,
   .bus_req, .bus_we, .bus_burst, .bus_addr, .bus_ack);

/* lct_store.sv */
`timescale 1ns/100ps
`include "lct_params.svh"
module lct_store (
   input wire logic clk_sys,
   input wire logic rst,
   lct_store_if.mem s
);
   import lct_pkg::*;

   logic [20:0] tag_m [2][`LCT_SETS];
   logic [31:0] dat_m [2][`LCT_SETS*`LCT_WPL];
   logic [`LCT_SETS-1:0] lru_r;

   for (genvar w = 0; w < 2; w++)
   begin : g_way
      logic [`LCT_SETS-1:0] vld_r;
      logic [`LCT_SETS-1:0] dty_r;
      logic [`LCT_SETS-1:0] lck_r;
      assign s.tag[w] = tag_m[w][s.idx];
      assign s.vld[w] = vld_r[s.idx];
      assign s.dty[w] = dty_r[s.idx];
      assign s.lck[w] = lck_r[s.idx];
      assign s.rword[w] = dat_m[w][{s.idx, s.wrd}];

      always_ff @(posedge clk_sys)
      begin
         for (int b = 0; b < 4; b++)
            if (s.way == 1'(w) && s.wbe[b])
               dat_m[w][{s.idx, s.wrd}][8*b +: 8] <= s.wdata[8*b +: 8];
         if (s.way == 1'(w) && s.tag_we)
            tag_m[w][s.idx] <= s.wtag;
      end

      // a new lock on a fill outranks an unlock in the same cycle
      always_ff @(posedge clk_sys or posedge rst)
      begin
         if (rst)
         begin
            vld_r <= '0;
            dty_r <= '0;
            lck_r <= '0;
         end
         else
         begin
            if (s.unlock)
               lck_r <= '0;
            if (s.way == 1'(w) && s.tag_we)
            begin
               vld_r[s.idx] <= 1'b1;
               dty_r[s.idx] <= 1'b0;
               lck_r[s.idx] <= s.set_lck; // R4 R8
            end
            else if (s.way == 1'(w) && s.set_dty)
               dty_r[s.idx] <= 1'b1; // R9
         end
      end
   end

   assign s.lru = lru_r[s.idx];

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         lru_r <= {`LCT_SETS{`LCT_LRU_RST}};
      else if (s.lru_we)
         lru_r[s.idx] <= ~s.way; // R3 R7
   end
endmodule : lct_store

/* lct_store_if.sv */
`timescale 1ns/100ps
interface lct_store_if;
   logic [6:0] idx;
   logic [1:0] wrd;
   logic way;
   logic [3:0] wbe;
   logic [31:0] wdata;
   logic tag_we;
   logic [20:0] wtag;
   logic set_dty;
   logic set_lck;
   logic lru_we;
   logic unlock;
   logic [1:0][20:0] tag;
   logic [1:0] vld;
   logic [1:0] dty;
   logic [1:0] lck;
   logic lru;
   logic [1:0][31:0] rword;
   modport ctl (output idx, wrd, way, wbe, wdata, tag_we, wtag, set_dty, set_lck, lru_we, unlock,
      input tag, vld, dty, lck, lru, rword);
   modport mem (input idx, wrd, way, wbe, wdata, tag_we, wtag, set_dty, set_lck, lru_we, unlock,
      output tag, vld, dty, lck, lru, rword);
endinterface : lct_store_if

/* lct_tlb.sv */
`timescale 1ns/100ps
`include "lct_params.svh"
module lct_tlb (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wr,
   input wire logic [4:0] wr_idx,
   input wire lct_pkg::lct_tlbe_t wr_e,
   input wire logic xlat_en,
   input wire logic [3:0] asid,
   input wire logic [31:0] va,
   output logic miss,
   output logic [31:0] pa,
   output logic ci,
   output logic wt,
   output logic [2:0] grp
);
   import lct_pkg::*;

   // offset bits above the 4 KB page that pass through untranslated
   function automatic logic [19:0] pmask(input lct_psize_t ps);
      case (ps)
         PS_16K: pmask = `LCT_M16K;
         PS_256K: pmask = `LCT_M256K;
         PS_512K: pmask = `LCT_M512K;
         PS_8M: pmask = `LCT_M8M;
         default: pmask = `LCT_M4K;
      endcase
   endfunction : pmask

   lct_tlbe_t ent_r [`LCT_TLB_N];
   logic [`LCT_TLB_N-1:0] hit_v;
   lct_tlbe_t sel;
   logic found;
   logic [19:0] m;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < `LCT_TLB_N; i++)
            ent_r[i] <= '0;
      end
      else if (wr)
         ent_r[wr_idx] <= wr_e; // R14
   end

   for (genvar e = 0; e < `LCT_TLB_N; e++)
   begin : g_cmp
      assign hit_v[e] = ent_r[e].vld && ent_r[e].asid == asid
         && ((ent_r[e].epn ^ va[31:12]) & ~pmask(ent_r[e].ps)) == 20'h0; // R11 R12 R13
   end

   always_comb
   begin
      sel = '0;
      found = 1'b0;
      for (int i = 0; i < `LCT_TLB_N; i++)
      begin
         if (hit_v[i] && !found)
         begin
            sel = ent_r[i];
            found = 1'b1;
         end
      end
   end

   assign m = pmask(sel.ps); // R12
   assign miss = xlat_en && !found; // R14
   assign pa = xlat_en ? {(sel.rpn & ~m) | (va[31:12] & m), va[11:0]} : va;
   assign ci = xlat_en && sel.ci; // R10
   assign wt = xlat_en && sel.wt; // R9
   assign grp = xlat_en ? sel.grp : 3'h0; // R13
endmodule : lct_tlb

/* lct_top.sv */
`timescale 1ns/100ps
`include "lct_params.svh"
module lct_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic xlat_en,
   input wire logic [3:0] asid,
   input wire logic if_req,
   input wire logic [31:0] if_vaddr,
   output logic if_ack,
   output logic if_tlb_miss,
   output logic [31:0] if_rdata,
   output logic [2:0] if_group,
   input wire logic dc_req,
   input wire logic dc_we,
   input wire logic [3:0] dc_be,
   input wire logic [31:0] dc_vaddr,
   input wire logic [31:0] dc_wdata,
   output logic dc_ack,
   output logic dc_tlb_miss,
   output logic [31:0] dc_rdata,
   output logic [2:0] dc_group,
   input wire logic [1:0] lock_fill,
   input wire logic [1:0] unlock_all,
   input wire logic tlb_wr,
   input wire logic tlb_wr_side,
   input wire logic [4:0] tlb_wr_idx,
   input wire lct_pkg::lct_tlbe_t tlb_wr_entry,
   input wire logic scr_we,
   input wire logic [1:0] scr_sel,
   input wire logic [31:0] scr_wdata,
   output logic [31:0] scr_rdata,
   output logic bus_req,
   output logic bus_we,
   output logic bus_burst,
   output logic [31:0] bus_addr,
   output logic [31:0] bus_wdata,
   output logic [3:0] bus_be,
   input wire logic bus_ack,
   input wire logic [31:0] bus_rdata
);
   import lct_pkg::*;

   // ----------------------------------------------------------------
   // victim choice
   // ----------------------------------------------------------------
   // returns {usable, way}; usable low when both ways hold locked lines
   function automatic logic [1:0] pick_vic(input logic [1:0] v, input logic [1:0] l, input logic lru);
      if (!v[0])
         pick_vic = 2'h2;
      else if (!v[1])
         pick_vic = 2'h3;
      else if (l == 2'h3)
         pick_vic = 2'h0;
      else if (l[0])
         pick_vic = 2'h3;
      else if (l[1])
         pick_vic = 2'h2;
      else
         pick_vic = {1'b1, lru};
   endfunction : pick_vic

   // side 0 is instruction fetch, side 1 is load/store
   logic [1:0] req_w;
   logic [1:0] we_w;
   logic [31:0] va_w [2];
   logic [31:0] wd_w [2];
   logic [3:0] be_w [2];
   logic [1:0] ack_w;
   logic [1:0] tm_w;
   logic [31:0] rd_w [2];
   logic [2:0] gp_w [2];
   logic [1:0] breq_w;
   logic [1:0] bwe_w;
   logic [1:0] bbu_w;
   logic [31:0] bad_w [2];
   logic [31:0] bwd_w [2];
   logic [3:0] bbe_w [2];
   logic [1:0] gnt_r;
   logic [31:0] scr_r [`LCT_NSCR];

   assign req_w = {dc_req, if_req};
   assign we_w = {dc_we, 1'b0};
   assign va_w[0] = if_vaddr;
   assign va_w[1] = dc_vaddr;
   assign wd_w[0] = 32'h0;
   assign wd_w[1] = dc_wdata;
   assign be_w[0] = 4'hf;
   assign be_w[1] = dc_be;

   assign if_ack = ack_w[0];
   assign if_tlb_miss = tm_w[0];
   assign if_rdata = rd_w[0];
   assign if_group = gp_w[0];
   assign dc_ack = ack_w[1];
   assign dc_tlb_miss = tm_w[1];
   assign dc_rdata = rd_w[1];
   assign dc_group = gp_w[1];

   // ----------------------------------------------------------------
   // per-side translation and cache engine
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 2; g++)
   begin : g_side
      lct_store_if st ();
      lct_state_t state_r;
      logic [31:0] pa_r;
      logic vic_r;
      logic [1:0] cnt_r;
      logic [20:0] wbt_r;
      logic ack_r;
      logic tm_r;
      logic [31:0] rd_r;
      logic [2:0] gp_r;
      logic miss;
      logic ci;
      logic wt;
      logic [31:0] pa;
      logic [2:0] grp;
      logic [31:0] cpa;
      logic [1:0] hitv;
      logic hit;
      logic hway;
      logic vok;
      logic vway;
      logic go;
      logic acc;
      logic wr_hit;
      logic beat;
      logic last;

      lct_tlb u_tlb (
         .clk_sys(clk_sys),
         .rst(rst),
         .wr(tlb_wr && tlb_wr_side == 1'(g)),
         .wr_idx(tlb_wr_idx),
         .wr_e(tlb_wr_entry),
         .xlat_en(xlat_en),
         .asid(asid),
         .va(va_w[g]),
         .miss(miss),
         .pa(pa),
         .ci(ci),
         .wt(wt),
         .grp(grp)
      );

      lct_store u_st (
         .clk_sys(clk_sys),
         .rst(rst),
         .s(st)
      );

      // lookup uses the live address when idle, the latched one after
      assign cpa = (state_r == ST_IDLE) ? pa : pa_r;
      for (genvar w = 0; w < 2; w++)
      begin : g_hit
         assign hitv[w] = st.vld[w] && st.tag[w] == cpa[31:`LCT_TAG_LO]; // R1 R5
      end
      assign hit = |hitv;
      assign hway = hitv[1];
      assign {vok, vway} = pick_vic(st.vld, st.lck, st.lru); // R3 R4 R7 R8

      // one access in flight; a request held through its ack is not retaken
      assign go = state_r == ST_IDLE && req_w[g] && !ack_r;
      assign acc = go && !miss && !ci && hit; // R15
      assign wr_hit = acc && we_w[g];
      assign beat = gnt_r[g] && bus_ack;
      assign last = beat && cnt_r == `LCT_LAST_BEAT;

      assign st.idx = cpa[`LCT_IDX_HI:`LCT_IDX_LO];
      assign st.wrd = (state_r == ST_WB || state_r == ST_FILL) ? cnt_r : cpa[3:2];
      assign st.way = (state_r == ST_IDLE) ? hway : vic_r;
      assign st.wbe = wr_hit ? be_w[g] : (state_r == ST_FILL && beat) ? 4'hf : 4'h0;
      assign st.wdata = (state_r == ST_FILL) ? bus_rdata : wd_w[g];
      assign st.tag_we = state_r == ST_FILL && last;
      assign st.wtag = pa_r[31:`LCT_TAG_LO];
      assign st.set_dty = wr_hit && !wt; // R9
      assign st.set_lck = lock_fill[g]; // R4 R8
      assign st.lru_we = acc || st.tag_we; // R3 R7
      assign st.unlock = unlock_all[g];

      // -------------------------------------------------------------
      // sequencing
      // -------------------------------------------------------------
      always_ff @(posedge clk_sys or posedge rst)
      begin
         if (rst)
         begin
            state_r <= ST_IDLE;
            pa_r <= 32'h0;
            vic_r <= 1'b0;
            cnt_r <= 2'h0;
            wbt_r <= 21'h0;
         end
         else
         begin
            case (state_r)
               ST_IDLE:
               begin
                  if (go && !miss)
                  begin
                     pa_r <= pa;
                     cnt_r <= 2'h0;
                     if (ci || (we_w[g] && wt) || (!hit && !vok))
                        state_r <= ST_ONE; // R9 R10 R15
                     else if (!hit)
                     begin
                        vic_r <= vway;
                        wbt_r <= st.tag[vway];
                        if (st.vld[vway] && st.dty[vway])
                           state_r <= ST_WB; // R16
                        else
                           state_r <= ST_FILL; // R3 R7
                     end
                  end
               end
               ST_WB:
               begin
                  if (beat)
                     cnt_r <= cnt_r + 2'h1;
                  if (last)
                     state_r <= ST_FILL; // R16
               end
               ST_FILL:
               begin
                  if (beat)
                     cnt_r <= cnt_r + 2'h1;
                  if (last)
                     state_r <= ST_IDLE;
               end
               ST_ONE:
               begin
                  if (beat)
                     state_r <= ST_IDLE;
               end
               default:
                  state_r <= ST_IDLE;
            endcase
         end
      end

      // -------------------------------------------------------------
      // answer to the core
      // -------------------------------------------------------------
      // data side gets no answer at fill end: the held request is
      // retaken as a hit, which costs the one extra clock
      always_ff @(posedge clk_sys or posedge rst)
      begin
         if (rst)
         begin
            ack_r <= 1'b0;
            tm_r <= 1'b0;
            rd_r <= 32'h0;
            gp_r <= 3'h0;
         end
         else
         begin
            ack_r <= 1'b0;
            if (go)
            begin
               gp_r <= grp; // R13
               tm_r <= miss; // R14
            end
            if (go && (miss || (acc && !(we_w[g] && wt))))
               ack_r <= 1'b1; // R2 R6
            if (acc)
               rd_r <= st.rword[hway];
            if (state_r == ST_FILL && beat && cnt_r == pa_r[3:2])
               rd_r <= bus_rdata;
            if (g == 0 && state_r == ST_FILL && last)
               ack_r <= 1'b1; // R2
            if (state_r == ST_ONE && beat)
            begin
               ack_r <= 1'b1; // R15
               rd_r <= bus_rdata;
            end
         end
      end

      assign ack_w[g] = ack_r;
      assign tm_w[g] = tm_r;
      assign rd_w[g] = rd_r;
      assign gp_w[g] = gp_r;

      assign breq_w[g] = state_r != ST_IDLE;
      assign bwe_w[g] = state_r == ST_WB || (state_r == ST_ONE && we_w[g]);
      assign bbu_w[g] = state_r == ST_WB || state_r == ST_FILL; // R3 R7
      assign bad_w[g] = (state_r == ST_WB) ? {wbt_r, pa_r[`LCT_IDX_HI:`LCT_IDX_LO], cnt_r, 2'h0}
         : (state_r == ST_FILL) ? {pa_r[31:`LCT_IDX_LO], cnt_r, 2'h0} : pa_r;
      assign bwd_w[g] = (state_r == ST_WB) ? st.rword[vic_r] : wd_w[g]; // R16
      assign bbe_w[g] = (state_r == ST_ONE && we_w[g]) ? be_w[g] : 4'hf;
   end

   // ----------------------------------------------------------------
   // bus ownership
   // ----------------------------------------------------------------
   // data side wins a tie; the owner keeps the bus until its engine idles,
   // so a write-back and its fill never split
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         gnt_r <= 2'h0;
      else if (gnt_r == 2'h0)
         gnt_r <= breq_w[1] ? 2'h2 : breq_w[0] ? 2'h1 : 2'h0;
      else if ((gnt_r & breq_w) == 2'h0)
         gnt_r <= 2'h0;
   end

   assign bus_req = (gnt_r & breq_w) != 2'h0;
   assign bus_we = gnt_r[1] ? bwe_w[1] : bwe_w[0] && gnt_r[0];
   assign bus_burst = gnt_r[1] ? bbu_w[1] : bbu_w[0] && gnt_r[0];
   assign bus_addr = gnt_r[1] ? bad_w[1] : bad_w[0];
   assign bus_wdata = gnt_r[1] ? bwd_w[1] : bwd_w[0];
   assign bus_be = gnt_r[1] ? bbe_w[1] : bbe_w[0];

   // ----------------------------------------------------------------
   // table-walk scratch
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < `LCT_NSCR; i++)
            scr_r[i] <= 32'h0;
      end
      else if (scr_we && scr_sel < 2'(`LCT_NSCR))
         scr_r[scr_sel] <= scr_wdata; // R14
   end

   assign scr_rdata = (scr_sel < 2'(`LCT_NSCR)) ? scr_r[scr_sel] : 32'h0;
endmodule : lct_top

/* lct_top_bench.sv */
`timescale 1ns/100ps
module lct_top_bench;
   import lct_pkg::*;
   logic clk_sys, rst, xlat_en, if_req, if_ack, if_tlb_miss, dc_req, dc_we, dc_ack, dc_tlb_miss, slow;
   logic tlb_wr, tlb_wr_side, scr_we, bus_req, bus_we, bus_burst, bus_ack;
   logic [1:0] lock_fill, unlock_all, scr_sel;
   logic [2:0] if_group, dc_group;
   logic [3:0] asid, dc_be, bus_be;
   logic [4:0] tlb_wr_idx;
   logic [31:0] if_vaddr, if_rdata, dc_vaddr, dc_wdata, dc_rdata, scr_wdata, scr_rdata, bus_addr, bus_wdata, bus_rdata;
   lct_tlbe_t tlb_wr_entry;
   logic [31:0] mdl [logic [29:0]];
   logic [31:0] sz [5] = '{32'h1000, 32'h4000, 32'h40000, 32'h80000, 32'h800000};
   logic [31:0] sv [4];
   logic [31:0] va, pa, lb;
   int miscompares = 0;
   int check_count = 0;
   int seed, last_cyc, ci;
   lct_top dut (.clk_sys, .rst, .xlat_en, .asid, .if_req, .if_vaddr, .if_ack, .if_tlb_miss, .if_rdata, .if_group,
      .dc_req, .dc_we, .dc_be, .dc_vaddr, .dc_wdata, .dc_ack, .dc_tlb_miss, .dc_rdata, .dc_group, .lock_fill,
      .unlock_all, .tlb_wr, .tlb_wr_side, .tlb_wr_idx, .tlb_wr_entry, .scr_we, .scr_sel, .scr_wdata, .scr_rdata,
      .bus_req, .bus_we, .bus_burst, .bus_addr, .bus_wdata, .bus_be, .bus_ack, .bus_rdata);
   lct_bus_model slv (.clk_sys, .slow, .bus_req, .bus_we, .bus_addr, .bus_wdata, .bus_be, .bus_ack, .bus_rdata);
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // ----------
   // checking
   // ----------
   task automatic chk(input logic c, input string m);
      check_count++;
      if (c !== 1'b1)
      begin
         miscompares++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   function automatic logic [31:0] mval(input logic [31:0] a);
      return mdl.exists(a[31:2]) ? mdl[a[31:2]] : ({a[31:2], 2'h0} ^ 32'h3c5a96e1);
   endfunction : mval
   // one core access; nrd/nwr are the bus beats it must cost
   task automatic acc(input bit side, input bit we, input logic [31:0] a, input logic [31:0] p, input int nrd,
      input int nwr, input bit tm, input logic [2:0] grp);
      int r0, w0, n;
      logic [31:0] d, d0, rd;
      logic [3:0] be;
      r0 = slv.n_rd;
      w0 = slv.n_wr;
      n = 0;
      d = $random(seed);
      be = 4'($random(seed)) | 4'h1;
      @(negedge clk_sys);
      if (side)
      begin
         dc_req = 1'b1;
         dc_we = we;
         dc_be = be;
         dc_vaddr = a;
         dc_wdata = d;
      end
      else
      begin
         if_req = 1'b1;
         if_vaddr = a;
      end
      do
      begin
         @(negedge clk_sys);
         n++;
         if (n > 300)
         begin
            miscompares++;
            conclude();
         end
      end
      while ((side ? dc_ack : if_ack) !== 1'b1);
      rd = side ? dc_rdata : if_rdata;
      if_req = 1'b0;
      dc_req = 1'b0;
      last_cyc = n;
      chk((side ? dc_tlb_miss : if_tlb_miss) === tm, "tlb miss flag");
      chk(slv.n_rd - r0 == nrd && slv.n_wr - w0 == nwr, "bus beat count");
      if (!tm)
         chk((side ? dc_group : if_group) === grp, "protection group");
      if (!tm && !we)
         chk(rd === mval(p), "read data");
      if (!tm && nrd + nwr > 0)
         chk(slv.last_addr[31:4] === p[31:4], "physical bus address");
      if (!tm && nrd + nwr == 0)
         chk(n == 1, "hit latency");
      if (we && !tm)
      begin
         d0 = mval(p);
         for (int b = 0; b < 4; b++)
            if (be[b])
               d0[8*b +: 8] = d[8*b +: 8];
         mdl[p[31:2]] = d0;
      end
   endtask : acc
   task automatic ac0(input bit side, input bit we, input logic [31:0] a, input int nrd, input int nwr);
      acc(side, we, a, a, nrd, nwr, 1'b0, 3'h0);
   endtask : ac0
   // ----------
   // sequence
   // ----------
   initial
   begin
      seed = 32'h0f7a7637;
      {rst, xlat_en, if_req, dc_req, dc_we, slow, tlb_wr, tlb_wr_side, scr_we} = 9'h100;
      {asid, dc_be, tlb_wr_idx, lock_fill, unlock_all, scr_sel} = 19'h0;
      {if_vaddr, dc_vaddr, dc_wdata, scr_wdata} = 128'h0;
      tlb_wr_entry = '0;
      repeat (10) @(negedge clk_sys);
      chk(if_ack === 1'b0 && dc_ack === 1'b0 && bus_req === 1'b0 && scr_rdata === 32'h0, "reset values");
      rst = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk_sys);
         scr_we = 1'b1;
         scr_sel = 2'(i);
         scr_wdata = $random(seed);
         sv[i] = (i < 3) ? scr_wdata : 32'h0;
      end
      @(negedge clk_sys);
      scr_we = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         scr_sel = 2'(i);
         @(posedge clk_sys);
         chk(scr_rdata === sv[i], "scratch word");
         @(negedge clk_sys);
      end
      ac0(0, 0, 32'h100, 4, 0);
      ci = last_cyc;
      ac0(0, 0, 32'h104, 0, 0);
      ac0(1, 0, 32'h2010, 4, 0);
      chk(last_cyc == ci + 1, "data miss extra clock");
      ac0(1, 0, 32'h2810, 4, 0);
      ac0(1, 0, 32'h2010, 0, 0);
      ac0(1, 0, 32'h3010, 4, 0);
      ac0(1, 0, 32'h2010, 0, 0);
      ac0(1, 0, 32'h2810, 4, 0);
      slow = 1'b1;
      ac0(1, 1, 32'h3020, 4, 0);
      ac0(1, 1, 32'h3024, 0, 0);
      ac0(1, 0, 32'h3820, 4, 0);
      ac0(1, 0, 32'h4020, 4, 4);
      ac0(1, 0, 32'h3024, 4, 0);
      slow = 1'b0;
      for (int s = 0; s < 2; s++)
      begin
         lb = s ? 32'h5050 : 32'h4040;
         lock_fill[s] = 1'b1;
         ac0(s, 0, lb, 4, 0);
         lock_fill[s] = 1'b0;
         ac0(s, 0, lb + 32'h800, 4, 0);
         ac0(s, 0, lb + 32'h1000, 4, 0);
         ac0(s, 0, lb, 0, 0);
         unlock_all[s] = 1'b1;
         @(negedge clk_sys);
         unlock_all[s] = 1'b0;
         ac0(s, 0, lb + 32'h1000, 0, 0);
         ac0(s, 0, lb + 32'h800, 4, 0);
         ac0(s, 0, lb, 4, 0);
      end
      // both ways of a set locked: the third line must bypass the cache
      lock_fill[1] = 1'b1;
      ac0(1, 0, 32'h6050, 4, 0);
      ac0(1, 0, 32'h6850, 4, 0);
      ac0(1, 0, 32'h7050, 1, 0);
      lock_fill[1] = 1'b0;
      xlat_en = 1'b1;
      asid = 4'h5;
      for (int i = 0; i < 6; i++)
      begin
         @(negedge clk_sys);
         tlb_wr = 1'b1;
         tlb_wr_side = (i < 5);
         tlb_wr_idx = (i < 5) ? 5'(i * 7) : 5'h1f;
         tlb_wr_entry = '{vld: 1'b1, epn: 20'h80000 + 20'(i * 32'h800), asid: 4'h5, ps: lct_psize_t'(3'(i)),
            rpn: 20'((i + 1) * 32'h800), grp: 3'(i), wt: 1'(i == 2), ci: 1'(i == 3)};
         if (i == 5)
            tlb_wr_entry = '{1'b1, 20'h90000, 4'h5, PS_4K, 20'h00008, 3'h7, 1'b0, 1'b0};
      end
      @(negedge clk_sys);
      tlb_wr = 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         va = {20'h80000 + 20'(i * 32'h800), 12'h0} + sz[i] - 32'hc;
         pa = {20'((i + 1) * 32'h800), 12'h0} + sz[i] - 32'hc;
         acc(1, i == 2, va, pa, i == 2 ? 0 : (i == 3 ? 1 : 4), i == 2, 0, 3'(i));
         acc(1, 0, va, pa, i == 3 ? 1 : (i == 2 ? 4 : 0), 0, 0, 3'(i));
         if (i == 2)
            acc(1, 1, va, pa, 0, 1, 0, 3'(i));
         acc(1, 0, va + sz[i], va + sz[i], 0, 0, 1, 3'h0);
      end
      asid = 4'h6;
      acc(1, 0, 32'h80000ff4, 32'h0, 0, 0, 1, 3'h0);
      asid = 4'h5;
      acc(0, 0, 32'h90000abc, 32'h00008abc, 4, 0, 0, 3'h7);
      acc(0, 0, 32'h91000000, 32'h0, 0, 0, 1, 3'h0);
      conclude();
   end
endmodule : lct_top_bench
